// file: gpcn_top.sv
// gpio ports a-f (no e) with input change notification behind an avalon-mm slave
`timescale 1ns/1ps

// Function
// [R01] Software waits one cycle between write and read
// [R02] Direction bits reset to one, pins inputs
// [R03] Enabled input change raises interrupt request
// [R04] Change detection works with clock stopped
// [R05] Twenty-four individually selectable change inputs
// [R06] Per-input interrupt enable, split low/high registers
// [R07] Per-input pull-up enable, same layout
// [R08] Small variant: only inputs 0 to 18
// [R09] Direction one input, zero drives latch
// [R10] Latch reads latch, port reads pins; writes hit latch
// [R11] Unimplemented bits disabled and read zero
// [R12] Peripheral drive disables port output driver
// [R13] Compare synchronized level against previous sample
// [R14] Pull-up follows only its own enable bit
module gpcn_top
    import gpcn_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
)
(
    input  wire logic                  SYS_CLK,
    input  wire logic                  RST,
    input  wire logic [ADDR_WIDTH-1:0] AVS_ADDRESS,
    input  wire logic                  AVS_READ,
    input  wire logic                  AVS_WRITE,
    input  wire logic [DATA_WIDTH-1:0] AVS_WRITEDATA,
    input  wire logic [BE_WIDTH-1:0]   AVS_BYTEENABLE,
    output logic      [DATA_WIDTH-1:0] AVS_READDATA,
    output logic                       AVS_WAITREQUEST,
    input  wire gpcn_ports_type        PORT_IN,
    output gpcn_ports_type             PORT_OUT,
    output gpcn_ports_type             PORT_OE_N,
    input  wire gpcn_ports_type        PERIPH_DRIVE,
    input  wire logic [CN_WIDTH-1:0]   CHANGE_IN,
    output logic      [CN_WIDTH-1:0]   CHANGE_PULLUP,
    output logic                       CHANGE_WAKE,
    output logic                       IRQ
);

    localparam logic [CN_WIDTH-1:0] CN_MASK =
        LARGE_VARIANT ? CN_MASK_LARGE : CN_MASK_SMALL; // [R05] [R08]

    gpcn_req_type req;

    gpcn_ports_type dir_reg;
    gpcn_ports_type dir_next;
    gpcn_ports_type lat_reg;
    gpcn_ports_type lat_next;
    gpcn_ports_type pin_meta_reg;
    gpcn_ports_type pin_sync_reg;

    logic [CN_WIDTH-1:0]   cn_irq_en_reg;
    logic [CN_WIDTH-1:0]   cn_irq_en_next;
    logic [CN_WIDTH-1:0]   cn_pu_en_reg;
    logic [CN_WIDTH-1:0]   cn_pu_en_next;
    logic [CN_WIDTH-1:0]   cn_status_reg;
    logic [CN_WIDTH-1:0]   cn_status_next;
    logic [CN_WIDTH-1:0]   cn_int_en_reg;
    logic [CN_WIDTH-1:0]   cn_int_en_next;
    logic [CN_WIDTH-1:0]   cn_meta_reg;
    logic [CN_WIDTH-1:0]   cn_sync_reg;
    logic [CN_WIDTH-1:0]   cn_prev_reg;
    logic [CN_WIDTH-1:0]   cn_event;

    logic                  ack_reg;
    logic                  ack_next;
    logic [DATA_WIDTH-1:0] rdata_reg;
    logic [DATA_WIDTH-1:0] rdata_next;
    logic [IDX_WIDTH-1:0]  idx;
    logic [PORT_WIDTH-1:0] wmask16;
    logic [CN_WIDTH-1:0]   wmask24;
    logic                  wr_go;
    logic [NUM_PORTS-1:0]  hit_dir;
    logic [NUM_PORTS-1:0]  hit_pin;
    logic [NUM_PORTS-1:0]  hit_lat;
    logic                  hit_irq_low;
    logic                  hit_irq_high;
    logic                  hit_pu_low;
    logic                  hit_pu_high;
    logic                  hit_status;
    logic                  hit_clear;
    logic                  hit_int_en;
    logic [PORT_WIDTH-1:0] wdata16;
    logic [CN_HIGH_W-1:0]  wdata8;
    logic [CN_WIDTH-1:0]   wdata24;

    assign req.read       = AVS_READ;
    assign req.write      = AVS_WRITE;
    assign req.address    = AVS_ADDRESS;
    assign req.writedata  = AVS_WRITEDATA;
    assign req.byteenable = AVS_BYTEENABLE;

    // registers sit one per aligned word; byte address is four times the index
    assign idx     = req.address[ADDR_WIDTH-1:2];
    assign wmask16 = {{8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
    assign wmask24 = {{8{req.byteenable[2]}}, wmask16};

    // every access answers on the second cycle; the write lands on the accepting edge
    assign AVS_WAITREQUEST = (req.read | req.write) & ~ack_reg;
    assign AVS_READDATA    = rdata_reg;
    assign wr_go           = req.write & ack_reg;

    // [R13] compare synchronized level with the previous sample
    assign cn_event = (cn_sync_reg ^ cn_prev_reg) & cn_irq_en_reg & CN_MASK; // [R03] [R06]

    // unclocked compare against the last sampled level so a pin edge wakes the core
    // even while SYS_CLK is stopped; outside the first synchroniser stage raw pins feed only this gate path
    assign CHANGE_WAKE = |((CHANGE_IN ^ cn_prev_reg) & cn_irq_en_reg & CN_MASK); // [R04]

    assign IRQ           = |(cn_status_reg & cn_int_en_reg);
    assign CHANGE_PULLUP = cn_pu_en_reg & CN_MASK; // [R07] [R14]

    // pin drive per port and bit
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++)
        begin : g_port
            assign PORT_OUT[gp]  = lat_reg[gp] & PORT_MASK[gp]; // [R11]
            // driver on only for implemented output bits not owned by a peripheral
            assign PORT_OE_N[gp] = ~(~dir_reg[gp] & PORT_MASK[gp] & ~PERIPH_DRIVE[gp]); // [R09] [R12]
        end
    endgenerate

    assign wdata16 = req.writedata[PORT_WIDTH-1:0];
    assign wdata8  = req.writedata[CN_HIGH_W-1:0];
    assign wdata24 = req.writedata[CN_WIDTH-1:0];

    // one decode feeds both the read mux and the write paths
    always_comb
    begin
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            hit_dir[p] = (idx == DIR_IDX[p]);
            hit_pin[p] = (idx == PIN_IDX[p]);
            hit_lat[p] = (idx == LAT_IDX[p]);
        end
        hit_irq_low  = (idx == CN_IRQ_LOW_IDX);
        hit_irq_high = (idx == CN_IRQ_HIGH_IDX);
        hit_pu_low   = (idx == CN_PU_LOW_IDX);
        hit_pu_high  = (idx == CN_PU_HIGH_IDX);
        hit_status   = (idx == CN_STATUS_IDX);
        hit_clear    = (idx == CN_CLEAR_IDX);
        hit_int_en   = (idx == CN_INT_EN_IDX);
    end

    // read data is captured on the edge that raises ack_reg and stands after it
    always_comb
    begin
        ack_next   = (req.read | req.write) & ~ack_reg;
        rdata_next = rdata_reg;
        if (req.read & ~ack_reg)
        begin
            rdata_next = '0;
            for (int p = 0; p < NUM_PORTS; p++)
            begin
                if (hit_dir[p])
                begin
                    rdata_next[PORT_WIDTH-1:0] = dir_reg[p] & PORT_MASK[p]; // [R11]
                end
                if (hit_pin[p])
                begin
                    rdata_next[PORT_WIDTH-1:0] = pin_sync_reg[p] & PORT_MASK[p]; // [R10] [R12]
                end
                if (hit_lat[p])
                begin
                    rdata_next[PORT_WIDTH-1:0] = lat_reg[p] & PORT_MASK[p]; // [R10]
                end
            end
            if (hit_irq_low)
            begin
                rdata_next[PORT_WIDTH-1:0] = cn_irq_en_reg[PORT_WIDTH-1:0]; // [R06]
            end
            if (hit_irq_high)
            begin
                rdata_next[CN_HIGH_W-1:0] = cn_irq_en_reg[CN_WIDTH-1:CN_HIGH_LSB]; // [R06]
            end
            if (hit_pu_low)
            begin
                rdata_next[PORT_WIDTH-1:0] = cn_pu_en_reg[PORT_WIDTH-1:0]; // [R07]
            end
            if (hit_pu_high)
            begin
                rdata_next[CN_HIGH_W-1:0] = cn_pu_en_reg[CN_WIDTH-1:CN_HIGH_LSB]; // [R07]
            end
            if (hit_status)
            begin
                rdata_next[CN_WIDTH-1:0] = cn_status_reg;
            end
            if (hit_int_en)
            begin
                rdata_next[CN_WIDTH-1:0] = cn_int_en_reg;
            end
            // the clear register and unmapped indices read as zero
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            ack_reg   <= 1'b0;
            rdata_reg <= '0;
        end
        else
        begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // a write to the pin register lands in the latch as well
    always_comb
    begin
        dir_next = dir_reg;
        lat_next = lat_reg;
        if (wr_go)
        begin
            for (int p = 0; p < NUM_PORTS; p++)
            begin
                if (hit_dir[p])
                begin
                    dir_next[p] = ((dir_reg[p] & ~wmask16) | (wdata16 & wmask16))
                        & PORT_MASK[p]; // [R09]
                end
                if (hit_pin[p] || hit_lat[p])
                begin
                    lat_next[p] = ((lat_reg[p] & ~wmask16) | (wdata16 & wmask16))
                        & PORT_MASK[p]; // [R10]
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            dir_reg <= DIR_RESET; // [R02]
            lat_reg <= {NUM_PORTS{LAT_RESET}};
        end
        else
        begin
            dir_reg <= dir_next;
            lat_reg <= lat_next;
        end
    end

    // two-stage synchronisers; logic reads the second stage and cn_prev_reg, never the first stage
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            cn_meta_reg  <= CN_RESET;
            cn_sync_reg  <= CN_RESET;
            cn_prev_reg  <= CN_RESET;
        end
        else
        begin
            pin_meta_reg <= PORT_IN;
            pin_sync_reg <= pin_meta_reg;
            cn_meta_reg  <= CHANGE_IN;
            cn_sync_reg  <= cn_meta_reg; // [R13]
            cn_prev_reg  <= cn_sync_reg; // [R13]
        end
    end

    // unimplemented inputs never hold enable bits
    always_comb
    begin
        cn_irq_en_next = cn_irq_en_reg;
        if (wr_go && hit_irq_low)
        begin
            cn_irq_en_next[PORT_WIDTH-1:0] =
                (cn_irq_en_reg[PORT_WIDTH-1:0] & ~wmask16) | (wdata16 & wmask16); // [R06]
        end
        if (wr_go && hit_irq_high && req.byteenable[0])
        begin
            cn_irq_en_next[CN_WIDTH-1:CN_HIGH_LSB] = wdata8; // [R06]
        end
        cn_irq_en_next = cn_irq_en_next & CN_MASK; // [R08]
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            cn_irq_en_reg <= CN_RESET;
        end
        else
        begin
            cn_irq_en_reg <= cn_irq_en_next;
        end
    end

    // pull-ups are kept apart from the interrupt enables on purpose
    always_comb
    begin
        cn_pu_en_next = cn_pu_en_reg;
        if (wr_go && hit_pu_low)
        begin
            cn_pu_en_next[PORT_WIDTH-1:0] =
                (cn_pu_en_reg[PORT_WIDTH-1:0] & ~wmask16) | (wdata16 & wmask16); // [R07]
        end
        if (wr_go && hit_pu_high && req.byteenable[0])
        begin
            cn_pu_en_next[CN_WIDTH-1:CN_HIGH_LSB] = wdata8; // [R07]
        end
        cn_pu_en_next = cn_pu_en_next & CN_MASK; // [R08] [R14]
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            cn_pu_en_reg <= CN_RESET;
        end
        else
        begin
            cn_pu_en_reg <= cn_pu_en_next;
        end
    end

    // the interrupt enable only gates status onto IRQ; status still records
    always_comb
    begin
        cn_int_en_next = cn_int_en_reg;
        if (wr_go && hit_int_en)
        begin
            cn_int_en_next = (cn_int_en_reg & ~wmask24) | (wdata24 & wmask24);
        end
        cn_int_en_next = cn_int_en_next & CN_MASK;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            cn_int_en_reg <= CN_RESET;
        end
        else
        begin
            cn_int_en_reg <= cn_int_en_next;
        end
    end

    // a change in the same cycle as its clear keeps the bit set
    always_comb
    begin
        cn_status_next = cn_status_reg;
        if (wr_go && hit_clear)
        begin
            cn_status_next = cn_status_reg & ~(wdata24 & wmask24);
        end
        cn_status_next = cn_status_next | cn_event; // [R03] [R05]
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            cn_status_reg <= CN_RESET;
        end
        else
        begin
            cn_status_reg <= cn_status_next;
        end
    end

endmodule

// file: gpcn_pkg.sv
// shared constants and types for the gpio ports and change notification block
package gpcn_pkg;

    localparam int NUM_PORTS  = 5;
    localparam int PORT_WIDTH = 16;
    localparam int CN_WIDTH   = 24;
    localparam int IDX_WIDTH  = 10;
    localparam int ADDR_WIDTH = 12;
    localparam int DATA_WIDTH = 32;
    localparam int BE_WIDTH   = 4;
    localparam int SYNC_DEPTH = 2;

    typedef logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] gpcn_ports_type;
    typedef logic [NUM_PORTS-1:0][IDX_WIDTH-1:0]  gpcn_idx_type;

    // port order in every array: a, b, c, d, f
    localparam gpcn_idx_type DIR_IDX = {10'h2de, 10'h2d2, 10'h2cc, 10'h2c6, 10'h2c0};
    localparam gpcn_idx_type PIN_IDX = {10'h2e0, 10'h2d4, 10'h2ce, 10'h2c8, 10'h2c2};
    localparam gpcn_idx_type LAT_IDX = {10'h2e2, 10'h2d6, 10'h2d0, 10'h2cb, 10'h2c4};

    // implemented bits equal the direction reset values
    localparam gpcn_ports_type PORT_MASK = {16'h007f, 16'h030f, 16'he000, 16'h1fff, 16'h0800};
    localparam gpcn_ports_type DIR_RESET = PORT_MASK;
    localparam logic [PORT_WIDTH-1:0] LAT_RESET = 16'h0000;

    localparam logic [IDX_WIDTH-1:0] CN_IRQ_LOW_IDX   = 10'h0c0;
    localparam logic [IDX_WIDTH-1:0] CN_IRQ_HIGH_IDX  = 10'h0c2;
    localparam logic [IDX_WIDTH-1:0] CN_PU_LOW_IDX    = 10'h0c4;
    localparam logic [IDX_WIDTH-1:0] CN_PU_HIGH_IDX   = 10'h0c6;
    localparam logic [IDX_WIDTH-1:0] CN_STATUS_IDX    = 10'h0c8;
    localparam logic [IDX_WIDTH-1:0] CN_CLEAR_IDX     = 10'h0ca;
    localparam logic [IDX_WIDTH-1:0] CN_INT_EN_IDX    = 10'h0cc;

    localparam logic [CN_WIDTH-1:0] CN_MASK_LARGE = 24'hffffff;
    localparam logic [CN_WIDTH-1:0] CN_MASK_SMALL = 24'h07ffff;
    localparam logic [CN_WIDTH-1:0] CN_RESET      = 24'h000000;
    localparam int CN_HIGH_LSB = 16;
    localparam int CN_HIGH_W   = 8;

    typedef struct packed {
        logic                  read;
        logic                  write;
        logic [ADDR_WIDTH-1:0] address;
        logic [DATA_WIDTH-1:0] writedata;
        logic [BE_WIDTH-1:0]   byteenable;
    } gpcn_req_type;

endpackage

// file: gpcn_props.sv
// concurrent checks on the ports of the gpio and change notification top
`timescale 1ns/1ps
module gpcn_props
    import gpcn_pkg::*;
(
    input wire logic                SYS_CLK,
    input wire logic                RST,
    input wire logic                AVS_READ,
    input wire logic                AVS_WRITE,
    input wire logic                AVS_WAITREQUEST,
    input wire gpcn_ports_type      PORT_OUT,
    input wire gpcn_ports_type      PORT_OE_N,
    input wire gpcn_ports_type      PERIPH_DRIVE,
    input wire logic [CN_WIDTH-1:0] CHANGE_PULLUP,
    input wire logic                CHANGE_WAKE,
    input wire logic                IRQ
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    a_one_wait: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("read not answered after one wait state");
    a_periph_owns: assert property ((PERIPH_DRIVE & ~PORT_OE_N) == '0)
        else $error("port drives a pin the peripheral owns");
    a_unimpl_quiet: assert property (((PORT_OUT | ~PORT_OE_N) & ~PORT_MASK) == '0)
        else $error("unimplemented bit active");
    a_reset_inputs: assert property ($past(RST) |-> PORT_OE_N == '1 && PORT_OUT == '0)
        else $error("pins not inputs after reset");
    a_irq_cause: assert property ($rose(IRQ) |-> $past(AVS_WRITE) || $past(CHANGE_WAKE, 2))
        else $error("irq rose without change or write");
    a_pullup_hold: assert property (!$past(AVS_WRITE) |-> $stable(CHANGE_PULLUP))
        else $error("pull-up moved without a write");
    a_latch_hold: assert property (!$past(AVS_WRITE) |-> $stable(PORT_OUT))
        else $error("latch moved without a write");
    a_wake_ends: assert property (CHANGE_WAKE |-> ##[1:6] !CHANGE_WAKE)
        else $error("wake stuck after sampling");
    c_irq: cover property ($rose(IRQ));
    c_wake: cover property ($rose(CHANGE_WAKE));
    c_periph: cover property ((PERIPH_DRIVE & PORT_OE_N) != '0);
endmodule

// file: gpcn_pins.sv
// board model: pin levels seen by the port inputs
`timescale 1ns/1ps
module gpcn_pins
    import gpcn_pkg::*;
(
    input wire gpcn_ports_type port_out,
    input wire gpcn_ports_type port_oe_n,
    input wire gpcn_ports_type ext_port,
    output gpcn_ports_type     port_in
);
    // a driven pin shows the latch, else the board level
    assign port_in = (port_out & ~port_oe_n) | (ext_port & port_oe_n);
endmodule

// file: tb_gpcn_top.sv
// self-checking bench for the gpio ports and change notification block
`timescale 1ns/1ps
module tb_gpcn_top
    import gpcn_pkg::*;
;
    logic                  clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wq, wake, irq;
    logic [ADDR_WIDTH-1:0] adr = '0;
    logic [DATA_WIDTH-1:0] wd  = '0, rdat;
    logic [CN_WIDTH-1:0]   cn  = '0, cpu;
    gpcn_ports_type        ext = '0, per = '0, pin, pout, oen;
    int                    miscompares = 0, checked = 0;
    always #2.5 clk = ~clk;
    gpcn_top gpcn_top_i(.SYS_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wq), .PORT_IN(pin), .PORT_OUT(pout), .PORT_OE_N(oen),
        .PERIPH_DRIVE(per), .CHANGE_IN(cn), .CHANGE_PULLUP(cpu), .CHANGE_WAKE(wake), .IRQ(irq));
    gpcn_pins gpcn_pins_i(.port_out(pout), .port_oe_n(oen), .ext_port(ext), .port_in(pin));
    task automatic finish_test();
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [IDX_WIDTH-1:0] i, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        rd  <= ~w;
        wr  <= w;
        adr <= {i, 2'b00};
        wd  <= d;
        @(posedge clk);
        for (n = 0; n < 50 && wq !== 1'b0; n++)
            @(posedge clk);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        chk({31'h0, wq}, 32'h0);
        if (wq !== 1'b0)
            finish_test();
        // idle edge keeps the settling cycle software owes before a read
        @(posedge clk);
    endtask
    function automatic logic [15:0] pin_exp(input logic [15:0] dr, lt, pr, ex, m);
        return ((~dr & ~pr & lt) | ((dr | pr) & ex)) & m;
    endfunction
    initial
    begin
        logic [31:0] d, q;
        int          b;
        void'($urandom(32'he34e));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            d = $urandom;
            ext[p] <= 16'($urandom);
            per[p] <= 16'($urandom);
            bus(1'b0, DIR_IDX[p], 0, q);
            chk(q, DIR_RESET[p]);
            bus(1'b1, DIR_IDX[p], d, q);
            bus(1'b1, p[0] ? PIN_IDX[p] : LAT_IDX[p], d[31:16], q);
            bus(1'b0, LAT_IDX[p], 0, q);
            chk(q, d[31:16] & PORT_MASK[p]);
            bus(1'b0, PIN_IDX[p], 0, q);
            chk(q, pin_exp(d[15:0], d[31:16], per[p], ext[p], PORT_MASK[p]));
        end
        bus(1'b1, CN_INT_EN_IDX, 32'hffffff, q);
        for (int k = 0; k < 8; k++)
        begin
            b = (k < 2) ? 23 * k : $urandom_range(23, 0);
            d = $urandom;
            bus(1'b1, CN_IRQ_LOW_IDX, d[15:0], q);
            bus(1'b1, CN_IRQ_HIGH_IDX, d[23:16], q);
            cn[b] <= ~cn[b];
            #1 chk(wake, d[b]);
            repeat (6) @(posedge clk);
            bus(1'b0, CN_STATUS_IDX, 0, q);
            chk(q, {31'h0, d[b]} << b);
            chk(irq, d[b]);
            bus(1'b1, CN_CLEAR_IDX, 32'hffffff, q);
            chk(irq, 0);
        end
        d = $urandom;
        bus(1'b1, CN_PU_LOW_IDX, d[15:0], q);
        bus(1'b1, CN_PU_HIGH_IDX, d[23:16], q);
        chk(cpu, d[23:0]);
        bus(1'b0, 10'h3ff, 0, q);
        chk(q, 0);
        finish_test();
    end
endmodule
bind gpcn_top gpcn_props gpcn_props_i(.SYS_CLK, .RST, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST,
    .PORT_OUT, .PORT_OE_N, .PERIPH_DRIVE, .CHANGE_PULLUP, .CHANGE_WAKE, .IRQ);
